// >>> src/mir_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "mir_map.svh"

module mir_regs (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [8:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output var  logic [7:0]  reg_rdata,
    input  wire logic        one_second_tick,
    input  wire logic [83:0] bip_err_count,
    input  wire logic [83:0] far_err_count,
    input  wire logic [55:0] rx_o_bits,
    input  wire logic [55:0] rx_trace_byte,
    input  wire logic [55:0] rx_growth_byte_a,
    input  wire logic [55:0] rx_growth_byte_b,
    input  wire logic [6:0]  remote_block_error_seen,
    input  wire logic [6:0]  remote_payload_defect_seen,
    input  wire logic [6:0]  remote_server_defect_seen,
    input  wire logic [6:0]  remote_connectivity_defect_seen,
    output var  logic [55:0] tx_o_bits,
    output var  logic [55:0] tx_trace_byte,
    output var  logic [55:0] tx_growth_byte_a,
    output var  logic [55:0] tx_growth_byte_b,
    output var  logic        soft_reset_active,
    output var  logic        interrupt_output_pin
);

    localparam int NCH = `MIR_NUM_CH;

    mir_pkg::mir_rst_state_t rst_state_q;
    mir_pkg::mir_rst_state_t rst_state_d;
    mir_pkg::mir_byte_t      scratch_q;
    mir_pkg::mir_byte_t      scratch_d;
    mir_pkg::mir_byte_t      gctrl_q;
    mir_pkg::mir_byte_t      gctrl_d;
    mir_pkg::mir_byte_t      rdata_q;
    mir_pkg::mir_byte_t      rdata_d;
    mir_pkg::mir_byte_t      glob_rdata;
    mir_pkg::mir_byte_t      ch_rdata [NCH];
    logic                    tick_q;
    logic                    irq_q;
    logic                    irq_d;
    logic                    held;
    logic                    latch_now;
    logic [4*NCH-1:0]        evt_status;

    // ---------------------------------------------------------
    // Soft reset state
    // ---------------------------------------------------------
    // The hardware reset lands in the held state, so the part stays quiet
    // until software has written a release value.
    always_comb
    begin
        rst_state_d = rst_state_q;
        if (reg_wr && reg_addr == `MIR_OFF_SOFT_RESET)
        begin
            if (reg_wdata == `MIR_SOFT_RESET_KEY)
            begin
                rst_state_d = mir_pkg::MIR_HELD;
            end
            else
            begin
                rst_state_d = mir_pkg::MIR_RUN;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_state_q <= mir_pkg::MIR_HELD;
        end
        else
        begin
            rst_state_q <= rst_state_d;
        end
    end

    assign held              = (rst_state_q == mir_pkg::MIR_HELD);
    assign soft_reset_active = held;

    // ---------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------
    // Scratch and global control are configuration, so soft reset spares them.
    always_comb
    begin
        scratch_d = scratch_q;
        gctrl_d   = gctrl_q;
        if (reg_wr && reg_addr == `MIR_OFF_SCRATCH)
        begin
            scratch_d = reg_wdata;
        end
        if (reg_wr && reg_addr == `MIR_OFF_GLOBAL_CTRL)
        begin
            gctrl_d = reg_wdata & `MIR_GC_WR_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scratch_q <= `MIR_SCRATCH_RESET;
            gctrl_q   <= `MIR_GC_RESET;
        end
        else
        begin
            scratch_q <= scratch_d;
            gctrl_q   <= gctrl_d;
        end
    end

    // ---------------------------------------------------------
    // One-second latch strobe and interrupt pin
    // ---------------------------------------------------------
    // Counters are copied only when monitoring and both edge bits are on.
    assign latch_now = one_second_tick & ~tick_q & ~held & gctrl_q[`MIR_GC_PM_BIT]
                     & gctrl_q[`MIR_GC_RISE_BIT] & gctrl_q[`MIR_GC_FALL_BIT];

    // The mask only gates the pin; the latched status keeps collecting events.
    always_comb
    begin
        irq_d = (|evt_status) & ~gctrl_q[`MIR_GC_MASK_BIT];
        irq_d = irq_d ^ gctrl_q[`MIR_GC_INV_BIT];
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_q <= 1'b0;
            irq_q  <= 1'b0;
        end
        else
        begin
            tick_q <= one_second_tick;
            irq_q  <= irq_d;
        end
    end

    assign interrupt_output_pin = irq_q;

    // ---------------------------------------------------------
    // Per-channel registers
    // ---------------------------------------------------------
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
        logic               sel;
        logic [5:0]         off;
        mir_pkg::mir_count_t lbec_q;
        mir_pkg::mir_count_t lbec_d;
        mir_pkg::mir_count_t lfec_q;
        mir_pkg::mir_count_t lfec_d;
        mir_pkg::mir_byte_t txo_q;
        mir_pkg::mir_byte_t txo_d;
        mir_pkg::mir_byte_t txj_q;
        mir_pkg::mir_byte_t txj_d;
        mir_pkg::mir_byte_t txa_q;
        mir_pkg::mir_byte_t txa_d;
        mir_pkg::mir_byte_t txb_q;
        mir_pkg::mir_byte_t txb_d;
        logic [3:0]         defect;
        logic [3:0]         clr;

        assign sel    = (reg_addr[8:6] == 3'(c + 1));
        assign off    = reg_addr[5:0];
        assign defect = {remote_block_error_seen[c], remote_payload_defect_seen[c],
                         remote_server_defect_seen[c], remote_connectivity_defect_seen[c]};
        assign clr    = (reg_wr && reg_addr == `MIR_OFF_EVT_BASE + 9'(c))
                      ? reg_wdata[3:0] : 4'h0;

        // Latched counters are state, so soft reset clears them; the tick
        // copy wins over a host write in the same cycle.
        always_comb
        begin
            lbec_d = lbec_q;
            lfec_d = lfec_q;
            txo_d  = txo_q;
            txj_d  = txj_q;
            txa_d  = txa_q;
            txb_d  = txb_q;
            if (reg_wr && sel)
            begin
                case (off)
                    `MIR_CH_LBEC_LOW:  lbec_d[7:0]  = reg_wdata;
                    `MIR_CH_LBEC_HIGH: lbec_d[11:8] = reg_wdata[3:0];
                    `MIR_CH_LFEC_LOW:  lfec_d[7:0]  = reg_wdata;
                    `MIR_CH_LFEC_HIGH: lfec_d[11:8] = reg_wdata[3:0];
                    `MIR_CH_TX_O:      txo_d        = reg_wdata;
                    `MIR_CH_TX_TRACE:  txj_d        = reg_wdata;
                    `MIR_CH_TX_GROW_A: txa_d        = reg_wdata;
                    `MIR_CH_TX_GROW_B: txb_d        = reg_wdata;
                    default:           txo_d        = txo_q;
                endcase
            end
            if (latch_now)
            begin
                lbec_d = bip_err_count[c*12 +: 12];
                lfec_d = far_err_count[c*12 +: 12];
            end
            if (held)
            begin
                lbec_d = 12'h000;
                lfec_d = 12'h000;
            end
        end

        always_ff @(posedge sys_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                lbec_q <= 12'h000;
                lfec_q <= 12'h000;
                txo_q  <= `MIR_CH_TX_RESET;
                txj_q  <= `MIR_CH_TX_RESET;
                txa_q  <= `MIR_CH_TX_RESET;
                txb_q  <= `MIR_CH_TX_RESET;
            end
            else
            begin
                lbec_q <= lbec_d;
                lfec_q <= lfec_d;
                txo_q  <= txo_d;
                txj_q  <= txj_d;
                txa_q  <= txa_d;
                txb_q  <= txb_d;
            end
        end

        // Channel read mux; reserved tail and unused offsets read zero.
        always_comb
        begin
            case (off)
                `MIR_CH_LBEC_LOW:  ch_rdata[c] = lbec_q[7:0];
                `MIR_CH_LBEC_HIGH: ch_rdata[c] = {4'h0, lbec_q[11:8]};
                `MIR_CH_LFEC_LOW:  ch_rdata[c] = lfec_q[7:0];
                `MIR_CH_LFEC_HIGH: ch_rdata[c] = {4'h0, lfec_q[11:8]};
                `MIR_CH_RX_O:      ch_rdata[c] = rx_o_bits[c*8 +: 8];
                `MIR_CH_RX_TRACE:  ch_rdata[c] = rx_trace_byte[c*8 +: 8];
                `MIR_CH_RX_GROW_A: ch_rdata[c] = rx_growth_byte_a[c*8 +: 8];
                `MIR_CH_RX_GROW_B: ch_rdata[c] = rx_growth_byte_b[c*8 +: 8];
                `MIR_CH_TX_O:      ch_rdata[c] = txo_q;
                `MIR_CH_TX_TRACE:  ch_rdata[c] = txj_q;
                `MIR_CH_TX_GROW_A: ch_rdata[c] = txa_q;
                `MIR_CH_TX_GROW_B: ch_rdata[c] = txb_q;
                `MIR_CH_DEFECT:    ch_rdata[c] = {4'h0, defect};
                default:           ch_rdata[c] = 8'h00;
            endcase
            if (!sel)
            begin
                ch_rdata[c] = 8'h00;
            end
        end

        // One edge latch per remote defect bit of this channel.
        for (genvar b = 0; b < 4; b++)
        begin : g_bit
            mir_evt_latch u_latch (
                .sys_clk  (sys_clk),
                .rst_n    (rst_n),
                .hold_clr (held),
                .cond     (defect[b]),
                .rise_en  (gctrl_q[`MIR_GC_RISE_BIT]),
                .fall_en  (gctrl_q[`MIR_GC_FALL_BIT]),
                .clr      (clr[b]),
                .status   (evt_status[c*4 + b])
            );
        end

        assign tx_o_bits[c*8 +: 8]        = txo_q;
        assign tx_trace_byte[c*8 +: 8]    = txj_q;
        assign tx_growth_byte_a[c*8 +: 8] = txa_q;
        assign tx_growth_byte_b[c*8 +: 8] = txb_q;
    end

    // ---------------------------------------------------------
    // Read data
    // ---------------------------------------------------------
    // Identity bytes are constants; unmapped common offsets read zero.
    always_comb
    begin
        case (reg_addr)
            `MIR_OFF_MAKER_LOW:   glob_rdata = {`MIR_MAKER_LOW7, 1'b1};
            `MIR_OFF_PART_MAKER:  glob_rdata = {`MIR_PART_LOW4,
                                                `MIR_MAKER_HIGH4};
            `MIR_OFF_PART_MID:    glob_rdata = `MIR_PART_MID8;
            `MIR_OFF_REV_PART:    glob_rdata = {`MIR_REVISION_CODE,
                                                `MIR_PART_HIGH4};
            `MIR_OFF_SCRATCH:     glob_rdata = scratch_q;
            `MIR_OFF_SOFT_RESET:  glob_rdata = held ? `MIR_RD_HELD
                                                    : `MIR_RD_RUNNING;
            `MIR_OFF_GLOBAL_CTRL: glob_rdata = gctrl_q;
            default:              glob_rdata = 8'h00;
        endcase
        for (int i = 0; i < NCH; i++)
        begin
            if (reg_addr == `MIR_OFF_EVT_BASE + 9'(i))
            begin
                glob_rdata = {4'h0, evt_status[i*4 +: 4]};
            end
        end
    end

    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            rdata_d = glob_rdata;
            for (int i = 0; i < NCH; i++)
            begin
                rdata_d = rdata_d | ch_rdata[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ---------------------------------------------------------
    // Checks
    // ---------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    id_low_a: assert property (reg_rd && reg_addr == `MIR_OFF_MAKER_LOW
        |=> reg_rdata == {`MIR_MAKER_LOW7, 1'b1}) else $error("maker byte wrong");
    part_mid_a: assert property (reg_rd && reg_addr == `MIR_OFF_PART_MID
        |=> reg_rdata == `MIR_PART_MID8) else $error("part byte wrong");
    rev_code_a: assert property (reg_rd && reg_addr == `MIR_OFF_REV_PART
        |=> reg_rdata[7:4] == `MIR_REVISION_CODE) else $error("revision wrong");
    scratch_rb_a: assert property ((reg_wr && reg_addr == `MIR_OFF_SCRATCH) ##1 !reg_wr
        ##1 (reg_rd && !reg_wr && reg_addr == `MIR_OFF_SCRATCH)
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("scratch lost");
    soft_enter_a: assert property (reg_wr && reg_addr == `MIR_OFF_SOFT_RESET
        && reg_wdata == `MIR_SOFT_RESET_KEY |=> soft_reset_active) else $error("stuck");
    soft_leave_a: assert property (reg_wr && reg_addr == `MIR_OFF_SOFT_RESET
        && reg_wdata != `MIR_SOFT_RESET_KEY |=> !soft_reset_active) else $error("held");
    reset_read_a: assert property (reg_rd && reg_addr == `MIR_OFF_SOFT_RESET
        |=> reg_rdata == ($past(held) ? 8'h01 : 8'h00)) else $error("reset read");
    irq_masked_a: assert property ($past(gctrl_q[`MIR_GC_MASK_BIT])
        |-> interrupt_output_pin == $past(gctrl_q[`MIR_GC_INV_BIT])) else $error("mask");
    irq_active_a: assert property (!$past(gctrl_q[`MIR_GC_MASK_BIT]) && $past(|evt_status)
        |-> interrupt_output_pin != $past(gctrl_q[`MIR_GC_INV_BIT])) else $error("irq");
    onset_latch_a: assert property ($rose(remote_payload_defect_seen[2])
        && gctrl_q[`MIR_GC_RISE_BIT] && !held |=> evt_status[10]) else $error("onset");
    end_latch_a: assert property ($fell(remote_payload_defect_seen[2])
        && gctrl_q[`MIR_GC_FALL_BIT] && !held |=> evt_status[10]) else $error("end");
    pm_copy_a: assert property (latch_now
        |=> g_ch[1].lbec_q == $past(bip_err_count[23:12])) else $error("pm copy");
    defect_read_a: assert property (reg_rd && reg_addr == 9'h07A
        |=> reg_rdata == {4'h0, $past(g_ch[0].defect)}) else $error("defect read");

endmodule // mir_regs

`default_nettype wire

// >>> src/mir_map.svh
// Operation
// - Read-only maker code: seven low bits in bits 7..1, bit 0 one, upper nibble.
// - Read-only 16-bit part code split over identification bytes two, three, four.
// - Read-only 4-bit revision code in upper nibble of fourth identification byte.
// - Eight-bit scratch register, read/write, never affects behaviour.
// - Writing 0x91 to reset location enters soft reset; non-configuration state cleared.
// - Writing any other value to reset location leaves soft reset.
// - Reset location reads 0x00 when running, 0x01 when held in reset.
// - Hardware reset input places device in soft reset until released.
// - Mask bit zero lets interrupt events drive the interrupt pin; one blocks it.
// - Interrupt status keeps updating while the mask is set, for polling.
// - Onset-latch bit set: condition start sets its latched status bit.
// - Clearance-latch bit set: condition end sets its latched status bit.
// - Polarity bit set inverts the interrupt pin's active level.
// - Each channel shows remote block error and three remote defect bits, low nibble.
// - With monitoring and both latch bits on, one-second tick edge copies counters.
`ifndef MIR_MAP_SVH
`define MIR_MAP_SVH

// -----------------------------------------------------------------
// Common map
// -----------------------------------------------------------------
`define MIR_OFF_MAKER_LOW   9'h000
`define MIR_OFF_PART_MAKER  9'h001
`define MIR_OFF_PART_MID    9'h002
`define MIR_OFF_REV_PART    9'h003
`define MIR_OFF_SCRATCH     9'h004
`define MIR_OFF_SOFT_RESET  9'h005
`define MIR_OFF_GLOBAL_CTRL 9'h006
`define MIR_OFF_EVT_BASE    9'h010

// Identity values; all three are arbitrary neutral codes.
`define MIR_MAKER_CODE      11'h2A5
`define MIR_PART_CODE       16'h5A3C
`define MIR_REVISION_CODE   4'h3
// The same codes cut into the fields that the identity bytes carry, because a
// literal from a macro cannot be part-selected where it is used.
`define MIR_MAKER_LOW7      7'h25
`define MIR_MAKER_HIGH4     4'h5
`define MIR_PART_LOW4       4'hC
`define MIR_PART_MID8       8'hA3
`define MIR_PART_HIGH4      4'h5

// -----------------------------------------------------------------
// Soft reset and global control
// -----------------------------------------------------------------
`define MIR_SOFT_RESET_KEY  8'h91
`define MIR_RD_RUNNING      8'h00
`define MIR_RD_HELD         8'h01
`define MIR_GC_MASK_BIT     7
`define MIR_GC_RISE_BIT     6
`define MIR_GC_FALL_BIT     5
`define MIR_GC_INV_BIT      4
`define MIR_GC_PM_BIT       3
`define MIR_GC_WR_MASK      8'hF8
`define MIR_GC_RESET        8'h00
`define MIR_SCRATCH_RESET   8'h00

// -----------------------------------------------------------------
// Per-channel map: channel c sits at base (c+1) * 0x40
// -----------------------------------------------------------------
`define MIR_CH_LBEC_LOW     6'h2E
`define MIR_CH_LBEC_HIGH    6'h2F
`define MIR_CH_LFEC_LOW     6'h30
`define MIR_CH_LFEC_HIGH    6'h31
`define MIR_CH_RX_O         6'h32
`define MIR_CH_RX_TRACE     6'h33
`define MIR_CH_RX_GROW_A    6'h34
`define MIR_CH_RX_GROW_B    6'h35
`define MIR_CH_TX_O         6'h36
`define MIR_CH_TX_TRACE     6'h37
`define MIR_CH_TX_GROW_A    6'h38
`define MIR_CH_TX_GROW_B    6'h39
`define MIR_CH_DEFECT       6'h3A
`define MIR_CH_TX_RESET     8'h00
`define MIR_NUM_CH          7

`endif

// >>> src/mir_pkg.sv
package mir_pkg;

    // Soft reset state of the whole device.
    typedef enum logic [0:0] {
        MIR_RUN  = 1'b0,
        MIR_HELD = 1'b1
    } mir_rst_state_t;

    typedef logic [7:0]  mir_byte_t;
    typedef logic [11:0] mir_count_t;

endpackage

// >>> src/mir_evt_latch.sv
`timescale 1ns/100ps
`default_nettype none

module mir_evt_latch (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic hold_clr,
    input  wire logic cond,
    input  wire logic rise_en,
    input  wire logic fall_en,
    input  wire logic clr,
    output var  logic status
);

    logic prev_q;
    logic prev_d;
    logic stat_q;
    logic stat_d;
    logic onset;
    logic ending;

    // ---------------------------------------------------------
    // Edge capture
    // ---------------------------------------------------------
    // A new edge beats a host clear in the same cycle, so no event is lost.
    always_comb
    begin
        prev_d = cond;
        onset  = cond & ~prev_q;
        ending = ~cond & prev_q;
        stat_d = stat_q & ~clr;
        if ((onset & rise_en) | (ending & fall_en))
        begin
            stat_d = 1'b1;
        end
        if (hold_clr)
        begin
            stat_d = 1'b0;
        end
    end

    // Only registers; the condition history keeps running during soft reset.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_q <= 1'b0;
            stat_q <= 1'b0;
        end
        else
        begin
            prev_q <= prev_d;
            stat_q <= stat_d;
        end
    end

    assign status = stat_q;

endmodule // mir_evt_latch

`default_nettype wire

// >>> tb/mir_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------
// Host processor on the register bus
// -----------------------------------------------------------------
module mir_host_model (
    input  wire logic       sys_clk,
    output var  logic [8:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // The bus is idle at time zero, with both strobes low.
    initial
    begin
        reg_addr  = 9'h1FF;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end

    // One write is taken at the edge after launch; the released lines are scrambled.
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    // Read data lands on the taking edge, so it is sampled just after it.
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule // mir_host_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "mir_map.svh"
// -----------------------------------------------------------------
// Register bank bench
// -----------------------------------------------------------------
module testbench;
    localparam logic [10:0] MK = `MIR_MAKER_CODE;
    localparam logic [15:0] PN = `MIR_PART_CODE;
    localparam logic [3:0]  RV = `MIR_REVISION_CODE;
    // Rows: address, write flag, write data, value read back.
    localparam logic [25:0] ROWS [0:15] = '{
        {9'h000, 1'b0, 8'h00, MK[6:0], 1'b1}, {9'h001, 1'b0, 8'h00, PN[3:0], MK[10:7]},
        {9'h002, 1'b0, 8'h00, PN[11:4]}, {9'h003, 1'b0, 8'h00, RV, PN[15:12]},
        {9'h000, 1'b1, 8'hFF, MK[6:0], 1'b1}, {9'h004, 1'b1, 8'hA5, 8'hA5},
        {9'h005, 1'b0, 8'h00, 8'h01}, {9'h005, 1'b1, 8'h00, 8'h00},
        {9'h006, 1'b1, 8'hFF, 8'hF8}, {9'h07A, 1'b0, 8'h00, 8'h09},
        {9'h0F6, 1'b1, 8'h3C, 8'h3C}, {9'h1F3, 1'b0, 8'h00, 8'h77},
        {9'h007, 1'b0, 8'h00, 8'h00}, {9'h177, 1'b1, 8'h5C, 8'h5C},
        {9'h0B8, 1'b1, 8'hC3, 8'hC3}, {9'h079, 1'b1, 8'h96, 8'h96}};
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        tick    = 1'b0;
    logic [83:0] bip     = '0;
    logic [83:0] far     = '0;
    logic [55:0] rxo     = 56'h11223344556677;
    logic [55:0] rxt     = 56'h778899AABBCCDD;
    logic [55:0] rxa     = 56'h0102030405060A;
    logic [55:0] rxb     = 56'hA0B0C0D0E0F090;
    logic [6:0]  rbe     = 7'h01;
    logic [6:0]  rpd     = 7'h00;
    logic [6:0]  rsd     = 7'h00;
    logic [6:0]  rcd     = 7'h01;
    logic [55:0] txo;
    logic [55:0] txj;
    logic [55:0] txa;
    logic [55:0] txb;
    logic        sra;
    logic        pin;
    logic [8:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [7:0]  d;
    int          num_errors = 0;
    int          n_checks = 0;

    // The clock flips every half period of 4 ns.
    always #4 sys_clk = ~sys_clk;

    mir_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    mir_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .one_second_tick(tick), .bip_err_count(bip), .far_err_count(far),
        .rx_o_bits(rxo), .rx_trace_byte(rxt), .rx_growth_byte_a(rxa),
        .rx_growth_byte_b(rxb), .remote_block_error_seen(rbe),
        .remote_payload_defect_seen(rpd), .remote_server_defect_seen(rsd),
        .remote_connectivity_defect_seen(rcd), .tx_o_bits(txo), .tx_trace_byte(txj),
        .tx_growth_byte_a(txa), .tx_growth_byte_b(txb), .soft_reset_active(sra),
        .interrupt_output_pin(pin));

    // Compares one byte and counts it; unknowns never match.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Lets the event latch and the registered pin settle: two edges plus one spare.
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // A hang is cut short and counted as a mismatch.
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        conclude();
    end

    // Main sequence: table first, then soft reset, interrupts and latching.
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            if (ROWS[i][16])
                host.wr(ROWS[i][25:17], ROWS[i][15:8]);
            host.rd(ROWS[i][25:17], d);
            chk(d, ROWS[i][7:0]);
        end
        chk(txo[23:16], 8'h3C);
        chk(txj[39:32], 8'h5C);
        chk(txa[15:8], 8'hC3);
        chk(txb[7:0], 8'h96);
        $display("test table done");
        host.wr(9'h005, 8'h91);
        host.rd(9'h005, d);
        chk(d, 8'h01);
        chk({7'h00, sra}, 8'h01);
        host.rd(9'h004, d);
        chk(d, 8'hA5);
        host.wr(9'h005, 8'h5A);
        host.rd(9'h005, d);
        chk(d, 8'h00);
        $display("test soft reset done");
        host.wr(9'h006, 8'h40);
        settle();
        chk({7'h00, pin}, 8'h00);
        @(posedge sys_clk);
        rpd[2] <= 1'b1;
        settle();
        chk({7'h00, pin}, 8'h01);
        host.rd(9'h012, d);
        chk(d, 8'h04);
        host.wr(9'h012, 8'h04);
        host.wr(9'h006, 8'h50);
        settle();
        chk({7'h00, pin}, 8'h01);
        host.wr(9'h006, 8'hE0);
        rpd[2] <= 1'b0;
        settle();
        chk({7'h00, pin}, 8'h00);
        host.rd(9'h012, d);
        chk(d, 8'h04);
        $display("test interrupt done");
        host.wr(9'h006, 8'h68);
        bip[23:12] <= 12'hABC;
        far[23:12] <= 12'h123;
        @(posedge sys_clk);
        tick <= 1'b1;
        settle();
        @(posedge sys_clk);
        bip[23:12] <= 12'h000;
        host.rd(9'h0AE, d);
        chk(d, 8'hBC);
        host.rd(9'h0AF, d);
        chk(d, 8'h0A);
        host.rd(9'h0B0, d);
        chk(d, 8'h23);
        host.rd(9'h0B1, d);
        chk(d, 8'h01);
        host.wr(9'h005, 8'h91);
        host.rd(9'h0AE, d);
        chk(d, 8'h00);
        host.wr(9'h005, 8'h00);
        $display("test latching done");
        // A hardware reset in mid-run must land in the held state again.
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({7'h00, sra}, 8'h01);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        host.rd(9'h005, d);
        chk(d, 8'h01);
        host.wr(9'h005, 8'h00);
        host.rd(9'h005, d);
        chk(d, 8'h00);
        $display("test hardware reset done");
        conclude();
    end
endmodule // testbench
`default_nettype wire
